// *** tcr_pkg.sv ***
// Constants, mode tables and helper functions for the timer register set.
package tcr_pkg;

    // Register offsets in I/O space.
    localparam logic [5:0] OFS_CAPTURE_LOW = 6'h26;
    localparam logic [5:0] OFS_CAPTURE_HIGH = 6'h27;
    localparam logic [5:0] OFS_CMP_B_LOW = 6'h28;
    localparam logic [5:0] OFS_CMP_B_HIGH = 6'h29;
    localparam logic [5:0] OFS_CMP_A_LOW = 6'h2A;
    localparam logic [5:0] OFS_CMP_A_HIGH = 6'h2B;
    localparam logic [5:0] OFS_COUNTER_LOW = 6'h2C;
    localparam logic [5:0] OFS_COUNTER_HIGH = 6'h2D;
    localparam logic [5:0] OFS_FLAGS = 6'h38;
    localparam logic [5:0] OFS_MASK = 6'h39;

    // Data-space accesses sit this far above the I/O offsets.
    localparam logic [7:0] DATA_SPACE_BASE = 8'h20;
    localparam logic [7:0] IO_SPACE_LIMIT = 8'h40;

    // Flag and mask bit positions.
    localparam int BIT_CAPTURE = 5;
    localparam int BIT_CMP_A = 4;
    localparam int BIT_CMP_B = 3;
    localparam int BIT_OVERFLOW = 2;
    localparam logic [7:0] FLAG_BITS = 8'h3C;

    // Values after reset.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Counter landmarks.
    localparam logic [15:0] MAX_VALUE = 16'hFFFF;
    localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;

    // Mode sets, one bit per waveform mode number.
    localparam logic [15:0] MODES_CAPTURE_TOP = 16'h5500;
    localparam logic [15:0] MODES_CMP_A_TOP = 16'h8A10;
    localparam logic [15:0] MODES_TOP_8BIT = 16'h0022;
    localparam logic [15:0] MODES_TOP_9BIT = 16'h0044;
    localparam logic [15:0] MODES_TOP_10BIT = 16'h0088;
    localparam logic [15:0] MODES_IMMEDIATE = 16'h3011;
    localparam logic [15:0] MODES_UPDATE_TOP = 16'h0C0E;
    localparam logic [15:0] MODES_OVF_TOP = 16'hC0E0;

    // Points of the count sequence.
    typedef enum logic [1:0] {PT_NOW, PT_MAX, PT_TOP, PT_BOTTOM} tcr_point_t;

    // Returns the TOP value of the given mode.
    function automatic logic [15:0] tcr_top_value(input logic [3:0] mode,
        input logic [15:0] cmp_a, input logic [15:0] capture);
        if (MODES_CAPTURE_TOP[mode])
            return capture;
        else if (MODES_CMP_A_TOP[mode])
            return cmp_a;
        else if (MODES_TOP_8BIT[mode])
            return TOP_8BIT;
        else if (MODES_TOP_9BIT[mode])
            return TOP_9BIT;
        else if (MODES_TOP_10BIT[mode])
            return TOP_10BIT;
        return MAX_VALUE;
    endfunction : tcr_top_value

    // Returns where the overflow flag is set in the given mode.
    function automatic tcr_point_t tcr_overflow_point(input logic [3:0] mode);
        if (MODES_IMMEDIATE[mode])
            return PT_MAX;
        else if (MODES_OVF_TOP[mode])
            return PT_TOP;
        return PT_BOTTOM;
    endfunction : tcr_overflow_point

    // Returns where buffered compare values become active.
    function automatic tcr_point_t tcr_update_point(input logic [3:0] mode);
        if (MODES_IMMEDIATE[mode])
            return PT_NOW;
        else if (MODES_UPDATE_TOP[mode])
            return PT_TOP;
        return PT_BOTTOM;
    endfunction : tcr_update_point

endpackage : tcr_pkg

// *** tcr_sync.sv ***
// Three-stage input synchroniser with filtered level and edge pulses.
`timescale 1ns/1ps
module tcr_sync
    import tcr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Asynchronous input.
    input wire logic pin_async,
    // Filtered edge pulses.
    output logic rise,
    output logic fall
);

    // Synchroniser chain; stage one feeds only stage two.
    logic [2:0] chain_reg;
    // Accepted level, changed only when stages two and three agree.
    logic level_reg;

    // Shift the pin into the chain.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            chain_reg <= 3'h0;
        else
            chain_reg <= {chain_reg[1:0], pin_async};
    end

    // Accept a new level and pulse the matching edge output.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            level_reg <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end
        else
        begin
            if (chain_reg[1] == chain_reg[2])
                level_reg <= chain_reg[2];
            rise <= (chain_reg[1] == chain_reg[2]) && chain_reg[2] && !level_reg;
            fall <= (chain_reg[1] == chain_reg[2]) && !chain_reg[2] && level_reg;
        end
    end

endmodule : tcr_sync

// *** tcr_cmp.sv ***
// One compare channel: full-width match, flag request and waveform event.
`timescale 1ns/1ps
module tcr_cmp
    import tcr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Counter side.
    input wire logic timer_tick,
    input wire logic blocked,
    input wire logic [15:0] counter_value,
    input wire logic [15:0] compare,
    // Software strobe.
    input wire logic force_strobe,
    // Results.
    output logic flag_set,
    output logic match_event
);

    // Match of the full word, valid during the current timer cycle.
    logic match;

    assign match = timer_tick && !blocked && (counter_value == compare);

    // Flag request only from a real match; event also from the strobe.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flag_set <= 1'b0;
            match_event <= 1'b0;
        end
        else
        begin
            flag_set <= match;
            match_event <= match || force_strobe;
        end
    end

endmodule : tcr_cmp

// *** tcr_regs.sv ***
// Compare, capture and interrupt register set of the 16-bit timer.
// Summary of operation
// - Compare write commits both bytes via temp
// - Capture read samples both bytes together
// - One temp byte serves all wide registers
// - Full-width compare against counter every timer tick
// - Capture copies counter on pin or comparator
// - Capture value can be the counter TOP
// - Capture interrupt needs enable, global, flag
// - Compare A interrupt needs enable, global, flag
// - Compare B interrupt needs enable, global, flag
// - Overflow interrupt needs enable, global, flag
// - Capture event sets capture flag
// - Capture-as-TOP sets flag at TOP instead
// - Compare A flag set tick after match
// - Compare B flag set tick after match
// - Force strobe never sets match flag
// - Overflow flag point follows waveform mode
// - Vector execution clears its flag
// - Writing one clears flag, zero keeps
// - I/O offsets, data space plus 0x20
// - Counter write blocks next tick's matches
// - Capture pin ignored when capture is TOP
// - Mode picks overflow and compare update points
`timescale 1ns/1ps
module tcr_regs
    import tcr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Processor I/O bus.
    input wire logic [7:0] io_addr,
    input wire logic io_data_space,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Counter datapath.
    input wire logic timer_tick,
    input wire logic [15:0] counter_value,
    input wire logic [3:0] waveform_mode_select,
    output logic counter_wr,
    output logic [15:0] counter_wr_data,
    output logic [15:0] counter_top,
    // Compare channels.
    input wire logic force_compare_a,
    input wire logic force_compare_b,
    output logic compare_a_event,
    output logic compare_b_event,
    // Capture sources.
    input wire logic capture_input_pin,
    input wire logic comparator_out,
    input wire logic capture_from_comparator,
    input wire logic capture_rising_edge,
    // Interrupt control.
    input wire logic global_irq_enable,
    input wire logic ack_capture,
    input wire logic ack_compare_a,
    input wire logic ack_compare_b,
    input wire logic ack_overflow,
    output logic irq_capture,
    output logic irq_compare_a,
    output logic irq_compare_b,
    output logic irq_overflow
);

    // Decoded I/O offset and hit.
    logic [7:0] io_ofs;
    logic io_hit;
    // Shared temporary high byte.
    logic [7:0] temp_reg;
    // Buffered (software) and active compare values.
    logic [15:0] cmp_a_buf_reg;
    logic [15:0] cmp_b_buf_reg;
    logic [15:0] cmp_a_reg;
    logic [15:0] cmp_b_reg;
    // Capture value, mask and flags.
    logic [15:0] capture_reg;
    logic [7:0] mask_reg;
    logic [7:0] flags_reg;
    // Match suppression after a counter write.
    logic cnt_block_reg;
    // Count sequence landmarks.
    logic [15:0] top_now;
    logic at_top;
    logic at_bottom;
    logic at_max;
    logic update_now;
    logic ovf_set;
    logic capture_is_top;
    // Capture source edges.
    logic pin_rise;
    logic pin_fall;
    logic acmp_rise;
    logic acmp_fall;
    logic cap_event;
    // Compare flag requests.
    logic cmp_a_set;
    logic cmp_b_set;
    // Flag set and clear vectors.
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    // Read multiplexer.
    logic [7:0] rd_mux;

    // True when the current access hits the given offset.
    function automatic logic io_at(input logic [5:0] ofs);
        return io_hit && (io_ofs[5:0] == ofs);
    endfunction : io_at

    always_comb
    begin
        io_ofs = io_data_space ? io_addr - DATA_SPACE_BASE : io_addr;
        io_hit = io_ofs < IO_SPACE_LIMIT;
    end

    // Landmarks of the count sequence for the selected mode.
    always_comb
    begin
        top_now = tcr_top_value(waveform_mode_select, cmp_a_reg, capture_reg);
        capture_is_top = MODES_CAPTURE_TOP[waveform_mode_select];
        at_top = timer_tick && (counter_value == top_now);
        at_bottom = timer_tick && (counter_value == BOTTOM_VALUE);
        at_max = timer_tick && (counter_value == MAX_VALUE);
        case (tcr_update_point(waveform_mode_select))
            PT_NOW: update_now = 1'b1;
            PT_TOP: update_now = at_top;
            default: update_now = at_bottom;
        endcase
        case (tcr_overflow_point(waveform_mode_select))
            PT_MAX: ovf_set = at_max;
            PT_TOP: ovf_set = at_top;
            default: ovf_set = at_bottom;
        endcase
    end

    // Capture source selection and edge polarity.
    always_comb
    begin
        if (capture_from_comparator)
            cap_event = capture_rising_edge ? acmp_rise : acmp_fall;
        else
            cap_event = capture_rising_edge ? pin_rise : pin_fall;
        if (capture_is_top)
            cap_event = 1'b0;
    end

    // Synchronisers for the two asynchronous capture sources.
    tcr_sync u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin_async(capture_input_pin),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    tcr_sync u_acmp_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin_async(comparator_out),
        .rise(acmp_rise),
        .fall(acmp_fall)
    );

    // Compare channels A and B.
    tcr_cmp u_cmp_a (
        .clk(clk),
        .rst_b(rst_b),
        .timer_tick(timer_tick),
        .blocked(cnt_block_reg),
        .counter_value(counter_value),
        .compare(cmp_a_reg),
        .force_strobe(force_compare_a),
        .flag_set(cmp_a_set),
        .match_event(compare_a_event)
    );

    tcr_cmp u_cmp_b (
        .clk(clk),
        .rst_b(rst_b),
        .timer_tick(timer_tick),
        .blocked(cnt_block_reg),
        .counter_value(counter_value),
        .compare(cmp_b_reg),
        .force_strobe(force_compare_b),
        .flag_set(cmp_b_set),
        .match_event(compare_b_event)
    );

    // Temporary high byte: loaded by high writes and counter or capture low reads.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            temp_reg <= RESET_BYTE;
        else if (io_wr && (io_at(OFS_CMP_A_HIGH) || io_at(OFS_CMP_B_HIGH) ||
                 io_at(OFS_CAPTURE_HIGH) || io_at(OFS_COUNTER_HIGH)))
            temp_reg <= io_wdata;
        else if (io_rd && io_at(OFS_COUNTER_LOW))
            temp_reg <= counter_value[15:8];
        else if (io_rd && io_at(OFS_CAPTURE_LOW))
            temp_reg <= capture_reg[15:8];
    end

    // Compare buffers take both bytes on the low-byte write.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmp_a_buf_reg <= RESET_WORD;
            cmp_b_buf_reg <= RESET_WORD;
        end
        else
        begin
            if (io_wr && io_at(OFS_CMP_A_LOW))
                cmp_a_buf_reg <= {temp_reg, io_wdata};
            if (io_wr && io_at(OFS_CMP_B_LOW))
                cmp_b_buf_reg <= {temp_reg, io_wdata};
        end
    end

    // Active compare values follow the buffers at the mode's update point.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmp_a_reg <= RESET_WORD;
            cmp_b_reg <= RESET_WORD;
        end
        else if (update_now)
        begin
            cmp_a_reg <= cmp_a_buf_reg;
            cmp_b_reg <= cmp_b_buf_reg;
        end
    end

    // Capture register; a capture event wins over a software write.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            capture_reg <= RESET_WORD;
        else if (cap_event)
            capture_reg <= counter_value;
        else if (io_wr && io_at(OFS_CAPTURE_LOW))
            capture_reg <= {temp_reg, io_wdata};
    end

    // Counter write goes out as a pulse and arms the match block.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            counter_wr <= 1'b0;
            counter_wr_data <= RESET_WORD;
            cnt_block_reg <= 1'b0;
        end
        else
        begin
            counter_wr <= io_wr && io_at(OFS_COUNTER_LOW);
            if (io_wr && io_at(OFS_COUNTER_LOW))
                counter_wr_data <= {temp_reg, io_wdata};
            if (io_wr && io_at(OFS_COUNTER_LOW))
                cnt_block_reg <= 1'b1;
            else if (timer_tick)
                cnt_block_reg <= 1'b0;
        end
    end

    // TOP value handed to the counter datapath.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            counter_top <= MAX_VALUE;
        else
            counter_top <= top_now;
    end

    // Flag set and clear sources.
    always_comb
    begin
        flag_set = RESET_BYTE;
        flag_set[BIT_CAPTURE] = cap_event || (capture_is_top && at_top);
        flag_set[BIT_CMP_A] = cmp_a_set;
        flag_set[BIT_CMP_B] = cmp_b_set;
        flag_set[BIT_OVERFLOW] = ovf_set;
        flag_clr = (io_wr && io_at(OFS_FLAGS)) ? io_wdata : RESET_BYTE;
        flag_clr[BIT_CAPTURE] = flag_clr[BIT_CAPTURE] || ack_capture;
        flag_clr[BIT_CMP_A] = flag_clr[BIT_CMP_A] || ack_compare_a;
        flag_clr[BIT_CMP_B] = flag_clr[BIT_CMP_B] || ack_compare_b;
        flag_clr[BIT_OVERFLOW] = flag_clr[BIT_OVERFLOW] || ack_overflow;
    end

    // Flags: a set in the same cycle as a clear wins.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            flags_reg <= RESET_BYTE;
        else
            flags_reg <= ((flags_reg & ~flag_clr) | flag_set) & FLAG_BITS;
    end

    // Interrupt mask; bits of other timers read as zero here.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            mask_reg <= RESET_BYTE;
        else if (io_wr && io_at(OFS_MASK))
            mask_reg <= io_wdata & FLAG_BITS;
    end

    // Interrupt requests: enable, global enable and flag together.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_capture <= 1'b0;
            irq_compare_a <= 1'b0;
            irq_compare_b <= 1'b0;
            irq_overflow <= 1'b0;
        end
        else
        begin
            irq_capture <= global_irq_enable && mask_reg[BIT_CAPTURE] &&
                           flags_reg[BIT_CAPTURE];
            irq_compare_a <= global_irq_enable && mask_reg[BIT_CMP_A] &&
                             flags_reg[BIT_CMP_A];
            irq_compare_b <= global_irq_enable && mask_reg[BIT_CMP_B] &&
                             flags_reg[BIT_CMP_B];
            irq_overflow <= global_irq_enable && mask_reg[BIT_OVERFLOW] &&
                            flags_reg[BIT_OVERFLOW];
        end
    end

    // Read data; high bytes of counter and capture come from temp.
    always_comb
    begin
        case (io_ofs[5:0])
            OFS_CAPTURE_LOW: rd_mux = capture_reg[7:0];
            OFS_CAPTURE_HIGH: rd_mux = temp_reg;
            OFS_CMP_B_LOW: rd_mux = cmp_b_buf_reg[7:0];
            OFS_CMP_B_HIGH: rd_mux = cmp_b_buf_reg[15:8];
            OFS_CMP_A_LOW: rd_mux = cmp_a_buf_reg[7:0];
            OFS_CMP_A_HIGH: rd_mux = cmp_a_buf_reg[15:8];
            OFS_COUNTER_LOW: rd_mux = counter_value[7:0];
            OFS_COUNTER_HIGH: rd_mux = temp_reg;
            OFS_FLAGS: rd_mux = flags_reg;
            OFS_MASK: rd_mux = mask_reg;
            default: rd_mux = RESET_BYTE;
        endcase
        if (!io_hit)
            rd_mux = RESET_BYTE;
    end

    // Read data register, updated on each read and held otherwise.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            io_rdata <= RESET_BYTE;
        else if (io_rd)
            io_rdata <= rd_mux;
    end

    // Checks on the register behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // High-byte write, one idle bus cycle, then low-byte write of compare A.
    sequence cmp_a_pair_s;
        (io_wr && io_at(OFS_CMP_A_HIGH)) ##1 !(io_wr || io_rd) ##1
        (io_wr && io_at(OFS_CMP_A_LOW));
    endsequence

    cmp_pair_write_a:
        assert property (cmp_a_pair_s |=> cmp_a_buf_reg ==
                         {$past(io_wdata, 3), $past(io_wdata)})
        else $error("compare A bytes not committed as a pair");

    capture_read_temp_a:
        assert property (io_rd && io_at(OFS_CAPTURE_LOW) |=>
                         temp_reg == $past(capture_reg[15:8]))
        else $error("capture high byte not latched on low read");

    cmp_a_flag_a:
        assert property (timer_tick && !cnt_block_reg &&
                         counter_value == cmp_a_reg |-> ##2 flags_reg[BIT_CMP_A])
        else $error("compare A flag not set after match");

    cmp_b_flag_a:
        assert property (timer_tick && !cnt_block_reg &&
                         counter_value == cmp_b_reg |-> ##2 flags_reg[BIT_CMP_B])
        else $error("compare B flag not set after match");

    force_no_flag_a:
        assert property (force_compare_a && !(timer_tick &&
                         counter_value == cmp_a_reg) |=> !cmp_a_set)
        else $error("force strobe raised a compare flag");

    counter_block_a:
        assert property ((io_wr && io_at(OFS_COUNTER_LOW)) ##1 timer_tick |=>
                         !cmp_a_set && !cmp_b_set)
        else $error("match not blocked after counter write");

    capture_copy_a:
        assert property (cap_event |=> capture_reg == $past(counter_value) &&
                         flags_reg[BIT_CAPTURE])
        else $error("capture did not copy counter and set flag");

    capture_top_off_a:
        assert property (capture_is_top && $stable(waveform_mode_select) &&
                         !(io_wr && io_at(OFS_CAPTURE_LOW)) |=> $stable(capture_reg))
        else $error("capture changed while used as top");

    irq_capture_a:
        assert property (global_irq_enable && mask_reg[BIT_CAPTURE] &&
                         flags_reg[BIT_CAPTURE] |=> irq_capture)
        else $error("capture interrupt not requested");

    irq_masked_a:
        assert property (!mask_reg[BIT_CMP_A] || !global_irq_enable |=> !irq_compare_a)
        else $error("compare A interrupt requested while masked");

    flag_w1c_a:
        assert property (io_wr && io_at(OFS_FLAGS) && io_wdata[BIT_OVERFLOW] &&
                         !ovf_set |=> !flags_reg[BIT_OVERFLOW])
        else $error("write of one did not clear overflow flag");

    ovf_normal_a:
        assert property (waveform_mode_select == 4'h0 && at_max |=>
                         flags_reg[BIT_OVERFLOW])
        else $error("overflow flag not set at max in normal mode");

endmodule : tcr_regs

// *** tcr_count_model.sv ***
// Counter datapath stand-in that feeds the register set.
`timescale 1ns/1ps
module tcr_count_model
    import tcr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Run control and software load.
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_value,
    // Count outputs.
    output logic tick,
    output logic [15:0] count
);
    // Ticks every cycle while running, so matches come quickly.
    assign tick = run;
    // A software load wins over counting, as a real counter would.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count <= RESET_WORD;
        else if (load)
            count <= load_value;
        else if (run)
            count <= count + 16'h0001;
    end
endmodule : tcr_count_model

// *** tb.sv ***
// Self-checking bench for the timer register set.
`timescale 1ns/1ps
`define CHK(n, e, a) samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end
module tb;
    import tcr_pkg::*;
    logic clk = 0, rst_b = 0, ds = 0, wr = 0, rd = 0, pin = 0, gie = 0, run = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
    logic [1:0] frc = 2'h0, ev;
    logic [3:0] ack = 4'h0, irq, mode = 4'h0;
    logic tick, cwr;
    logic [15:0] cval, cdata, top;
    int num_errors = 0, samples_checked = 0;
    // Reset values, then one unmapped offset that must read zero.
    logic [5:0] offs[6] = '{OFS_CAPTURE_LOW, OFS_CMP_A_HIGH, OFS_CMP_B_LOW, OFS_FLAGS,
        OFS_MASK, 6'h30};
    always #5 clk = ~clk;
    tcr_count_model model (.clk(clk), .rst_b(rst_b), .run(run), .load(cwr),
        .load_value(cdata), .tick(tick), .count(cval));
    tcr_regs DUT (.clk(clk), .rst_b(rst_b), .io_addr(addr), .io_data_space(ds),
        .io_wr(wr), .io_rd(rd), .io_wdata(wdata), .io_rdata(rdata), .timer_tick(tick),
        .counter_value(cval), .waveform_mode_select(mode), .counter_wr(cwr),
        .counter_wr_data(cdata), .counter_top(top), .force_compare_a(frc[1]),
        .force_compare_b(frc[0]), .compare_a_event(ev[1]), .compare_b_event(ev[0]),
        .capture_input_pin(pin), .comparator_out(1'b0), .capture_from_comparator(1'b0),
        .capture_rising_edge(1'b1), .global_irq_enable(gie), .ack_capture(ack[3]),
        .ack_compare_a(ack[2]), .ack_compare_b(ack[1]), .ack_overflow(ack[0]),
        .irq_capture(irq[3]), .irq_compare_a(irq[2]), .irq_compare_b(irq[1]),
        .irq_overflow(irq[0]));
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    // One bus access; read data is taken once the answer edge has passed.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk);
        wr = 0;
        rd = 0;
        r = rdata;
    endtask : acc
    // Waits a bounded time for one request line.
    task automatic wait_irq(input int i, input int lim);
        int n;
        n = 0;
        while (irq[i] !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("irq", 1'b1, irq[i])
        if (irq[i] !== 1'b1)
            give_verdict();
    endtask : wait_irq
    initial
    begin
        repeat (6) @(negedge clk);
        rst_b = 1;
        foreach (offs[i])
        begin
            acc(0, {2'b00, offs[i]}, 8'h00);
            `CHK("reset", 8'h00, r)
        end
        // High byte first, then the low byte commits both.
        acc(1, 8'h2B, 8'h12);
        acc(1, 8'h2A, 8'h34);
        acc(0, 8'h2A, 8'h00);
        `CHK("cmp a low", 8'h34, r)
        acc(0, 8'h2B, 8'h00);
        `CHK("cmp a high", 8'h12, r)
        // Mask through the data-space window.
        ds = 1;
        acc(1, 8'h59, 8'hFF);
        ds = 0;
        acc(0, 8'h39, 8'h00);
        `CHK("mask", 8'h3C, r)
        // Load the counter just below compare A and let it run.
        acc(1, 8'h2D, 8'h12);
        acc(1, 8'h2C, 8'h30);
        gie = 1;
        run = 1;
        wait_irq(2, 50);
        acc(1, 8'h38, 8'h00);
        acc(0, 8'h38, 8'h00);
        `CHK("zero keeps", 8'h10, r & 8'h10)
        acc(1, 8'h38, 8'h10);
        acc(0, 8'h38, 8'h00);
        `CHK("one clears", 8'h00, r & 8'h10)
        // Overflow at the top of the count, then the vector clears it.
        acc(1, 8'h2D, 8'hFF);
        acc(1, 8'h2C, 8'hF8);
        wait_irq(0, 50);
        @(negedge clk);
        ack[0] = 1;
        @(negedge clk);
        ack[0] = 0;
        repeat (2) @(negedge clk);
        `CHK("ack", 1'b0, irq[0])
        // Force strobes with the counter stopped.
        run = 0;
        acc(1, 8'h38, 8'h3C);
        @(negedge clk);
        frc = 2'h3;
        @(negedge clk);
        frc = 2'h0;
        `CHK("force events", 2'h3, ev)
        repeat (3) @(negedge clk);
        acc(0, 8'h38, 8'h00);
        `CHK("force", 8'h00, r)
        // Rising pin edge captures the frozen count.
        pin = 1;
        wait_irq(3, 20);
        acc(0, 8'h26, 8'h00);
        `CHK("cap low", cval[7:0], r)
        acc(0, 8'h27, 8'h00);
        `CHK("cap high", cval[15:8], r)
        // Capture value as TOP: pin edges ignored, flag raised at the TOP tick.
        pin = 0;
        mode = 4'hC;
        acc(1, 8'h38, 8'h3C);
        acc(1, 8'h27, 8'h00);
        acc(1, 8'h26, 8'h40);
        acc(1, 8'h2D, 8'h00);
        acc(1, 8'h2C, 8'h38);
        run = 1;
        pin = 1;
        wait_irq(3, 30);
        run = 0;
        `CHK("top", 16'h0040, top)
        acc(0, 8'h26, 8'h00);
        `CHK("cap kept", 8'h40, r)
        give_verdict();
    end
endmodule : tb
